/* hdl/cbs_pkg.sv */
package cbs_pkg;

   // ratio codes, in half steps: value = ratio * 2
   localparam logic [2:0] RATIO_2P0 = 3'h4;
   localparam logic [2:0] RATIO_2P5 = 3'h5;
   localparam logic [2:0] RATIO_3P0 = 3'h6;
   localparam logic [2:0] RATIO_3P5 = 3'h7;

   // two-strap codes {bit1, bit0}
   localparam logic [1:0] STRAP2_2P5 = 2'h0;
   localparam logic [1:0] STRAP2_3P0 = 2'h1;
   localparam logic [1:0] STRAP2_2P0 = 2'h2;
   localparam logic [1:0] STRAP2_3P5 = 2'h3;

   // line offsets, in quadword index units (0, 8, 10, 18 hex)
   localparam logic [1:0] QW_00 = 2'h0;
   localparam logic [1:0] QW_08 = 2'h1;
   localparam logic [1:0] QW_10 = 2'h2;
   localparam logic [1:0] QW_18 = 2'h3;
   localparam logic [2:0] BURST_BEATS = 3'h4;

   // reset values
   localparam logic       LINEAR_RST = 1'b0;
   localparam logic [2:0] RATIO_RST  = 3'h4;
   // pin idle levels: warm reset low, active-low pins and straps high
   localparam logic [6:0] PIN_RST      = 7'h77;
   // edges after release before straps are caught: three to fill, one to agree
   localparam logic [2:0] STRAP_SETTLE = 3'h4;

   typedef struct packed {
      logic [28:0] qaddr;
      logic [7:0]  byte_en;
      logic        write;
      logic        cache_req;
      logic        burst;
   } cbs_cycle_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0]  len;
      logic        write;
      logic        line_fill;
   } cbs_req_s;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_CYCLE  = 7'h02,
      ST_SINGLE = 7'h04,
      ST_BURST  = 7'h08,
      ST_WBACK  = 7'h10,
      ST_INVAL  = 7'h20,
      ST_WARM   = 7'h40
   } cbs_state_e;

endpackage

/* hdl/cbs_sequencer.sv */
// Summary of operation
// - single-strap part: ratio strap low gives 2.0, high gives 3.0.
// - two-strap part: codes 00=2.5, 01=3.0, 10=2.0, 11=3.5.
// - floating straps default to 2.0 ratio.
// - access inside one quadword is one bus cycle with byte enables.
// - access across two quadwords is two cycles, lower address first.
// - cache invalidate writes back every modified line before invalidating.
// - warm reset seen in idle enters initial state at once; otherwise it waits for instruction done back in idle.
// - warm reset keeps cache, write buffers, config and float registers.
// - at hard reset release, flush gives tristate test, warm reset gives self-test.
// - scatter/gather pins enabled only if strap sampled low at reset release.
// - with smm enable, smm active asserts while servicing smm interrupt.
// - smm active also asserts on entry instruction or space-access bit.
// - space-access bit routes accesses to smm memory without service routine.
// - smm return instruction negates smm active unless the space-access bit is set.
// - after reset burst order is 1+4 until linear is selected.
// - 1+4 mode: first address 8 or 18 gets a leading single read.
// - 1+4 bursts run 0-8-10-18 or 10-18-0-8 by half line.
// - single read samples cacheable ack; burst follows only if active.
// - cacheable request stays low during the leading single read.
// - linear bursts wrap upward from the first quadword.
// - a configuration bit selects linear burst mode.
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer
(
   input  wire logic                 clk_in,
   input  wire logic                 nrst_in,
   input  wire logic                 two_strap_in,
   input  wire logic                 ratio_strap_bit0_in,
   input  wire logic                 ratio_strap_bit1_in,
   input  wire logic                 warm_reset_in,
   input  wire logic                 flush_n_in,
   input  wire logic                 sg_enable_strap_n_in,
   input  wire logic                 smm_interrupt_in_n,
   input  wire logic                 smm_enable_bit_in,
   input  wire logic                 smm_space_access_bit_in,
   input  wire logic                 smm_entry_instr_in,
   input  wire logic                 smm_return_instr_in,
   input  wire logic                 linear_burst_bit_in,
   input  wire logic                 linear_burst_we_in,
   input  wire logic                 cache_invalidate_instr_in,
   input  wire logic                 instr_done_in,
   input  wire logic                 req_valid_in,
   input  wire cbs_pkg::cbs_req_s    req_in,
   input  wire logic                 line_dirty_in,
   input  wire logic                 bus_done_in,
   input  wire logic                 cacheable_ack_in_n,
   output logic                      req_ready_out,
   output logic                      cyc_valid_out,
   output cbs_pkg::cbs_cycle_s       cyc_out,
   output logic [1:0]                beat_qw_out,
   output logic [2:0]                ratio_out,
   output logic                      tristate_test_out,
   output logic                      self_test_out,
   output logic                      sg_enable_out,
   output logic                      smm_active_out_n,
   output logic                      smm_space_route_out,
   output logic                      line_fill_ok_out,
   output logic                      wb_line_req_out,
   output logic                      cache_inval_out,
   output logic                      warm_init_out,
   output logic                      linear_mode_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, change taken when stages two and three agree
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [6:0] sync3;
   logic [6:0] pin_clean;
   wire  [6:0] pin_raw = {two_strap_in, ratio_strap_bit0_in, ratio_strap_bit1_in, warm_reset_in,
                          flush_n_in, sg_enable_strap_n_in, smm_interrupt_in_n};

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1     <= cbs_pkg::PIN_RST;
         sync2     <= cbs_pkg::PIN_RST;
         sync3     <= cbs_pkg::PIN_RST;
         pin_clean <= cbs_pkg::PIN_RST;
      end
      else
      begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 7; i++)
            if (sync2[i] == sync3[i])
               pin_clean[i] <= sync3[i];
      end
   end

   wire two_strap = pin_clean[6];
   wire strap_b0  = pin_clean[5];
   wire strap_b1  = pin_clean[4];
   wire warm_rst  = pin_clean[3];
   wire flush_n   = pin_clean[2];
   wire sg_n      = pin_clean[1];
   wire smi_n     = pin_clean[0];

   ////////////////////////////////////////////////////////////////////////////
   // straps caught once, on the first settled cycle after reset release
   logic       straps_taken;
   wire [1:0]  strap_code = {strap_b1, strap_b0};
   logic [2:0] next_ratio;

   always_comb
   begin
      next_ratio = cbs_pkg::RATIO_2P0;
      if (!two_strap)
         next_ratio = strap_b0 ? cbs_pkg::RATIO_3P0 : cbs_pkg::RATIO_2P0;
      else
         unique case (strap_code)
            cbs_pkg::STRAP2_2P5: next_ratio = cbs_pkg::RATIO_2P5;
            cbs_pkg::STRAP2_3P0: next_ratio = cbs_pkg::RATIO_3P0;
            cbs_pkg::STRAP2_2P0: next_ratio = cbs_pkg::RATIO_2P0;
            cbs_pkg::STRAP2_3P5: next_ratio = cbs_pkg::RATIO_3P5;
         endcase
   end

   // the synchroniser fills in three edges and agrees on the fourth; earlier would latch idle levels
   logic [2:0] settle;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         settle            <= 3'h0;
         straps_taken      <= 1'b0;
         ratio_out         <= cbs_pkg::RATIO_RST;
         tristate_test_out <= 1'b0;
         self_test_out     <= 1'b0;
         sg_enable_out     <= 1'b0;
      end
      else if (!straps_taken)
      begin
         settle <= settle + 3'h1;
         if (settle == cbs_pkg::STRAP_SETTLE)
         begin
            straps_taken      <= 1'b1;
            ratio_out         <= next_ratio;
            tristate_test_out <= !flush_n;
            self_test_out     <= warm_rst;
            sg_enable_out     <= !sg_n;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system management mode
   logic smm_service;
   wire  smi_fall = !smi_n;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         smm_service <= 1'b0;
      else if (smm_return_instr_in)
         smm_service <= 1'b0;
      else if ((smm_enable_bit_in && smi_fall) || smm_entry_instr_in)
         smm_service <= 1'b1;
   end

   wire smm_any = smm_service || smm_space_access_bit_in;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         smm_active_out_n    <= 1'b1;
         smm_space_route_out <= 1'b0;
      end
      else
      begin
         smm_active_out_n    <= !smm_any;
         smm_space_route_out <= smm_space_access_bit_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // burst order selection; survives warm reset like other config state
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         linear_mode_out <= cbs_pkg::LINEAR_RST;
      else if (linear_burst_we_in)
         linear_mode_out <= linear_burst_bit_in;
   end

   // quadword for beat n of a burst starting at first
   function automatic logic [1:0] beat_qw(input logic lin, input logic [1:0] first, input logic [1:0] n);
      if (lin)
         beat_qw = first + n;
      else
         beat_qw = {first[1], 1'b0} + n;
   endfunction

   // byte enables for len bytes at offset off, lanes from off upward, clipped to a quadword
   function automatic logic [7:0] lane_mask(input logic [2:0] off, input logic [3:0] len);
      logic [15:0] m;
      m = 16'h0;
      m = ((16'h1 << len) - 16'h1) << off;
      lane_mask = m[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer
   cbs_pkg::cbs_state_e state;
   cbs_pkg::cbs_req_s   cur;
   logic                second_half;
   logic [1:0]          beat;
   logic [1:0]          first_qw;
   logic                warm_pend;

   wire [28:0] cur_qw    = cur.addr[31:3];
   wire [4:0]  span_end  = {2'h0, cur.addr[2:0]} + {1'b0, cur.len} - 5'h1;
   wire        splits    = span_end[3];
   wire [7:0]  lo_mask   = lane_mask(cur.addr[2:0], cur.len);
   wire [7:0]  hi_mask   = lane_mask(3'h0, 4'(span_end[3:0] - 4'h7));
   wire        odd_first = (cur.addr[4:3] == cbs_pkg::QW_08) || (cur.addr[4:3] == cbs_pkg::QW_18);
   wire        need_one  = !linear_mode_out && odd_first;
   wire        req_one   = !linear_mode_out && req_in.addr[3];
   wire        ack       = !cacheable_ack_in_n;
   wire        warm_now  = warm_rst && !warm_pend;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state            <= cbs_pkg::ST_IDLE;
         cur              <= '0;
         second_half      <= 1'b0;
         beat             <= 2'h0;
         first_qw         <= 2'h0;
         warm_pend        <= 1'b0;
         req_ready_out    <= 1'b0;
         cyc_valid_out    <= 1'b0;
         cyc_out          <= '0;
         beat_qw_out      <= 2'h0;
         line_fill_ok_out <= 1'b0;
         wb_line_req_out  <= 1'b0;
         cache_inval_out  <= 1'b0;
         warm_init_out    <= 1'b0;
      end
      else
      begin
         req_ready_out    <= 1'b0;
         line_fill_ok_out <= 1'b0;
         cache_inval_out  <= 1'b0;
         warm_init_out    <= 1'b0;
         if (warm_now)
            warm_pend <= 1'b1;
         else if (!warm_rst)
            warm_pend <= 1'b0;
         unique case (state)
            cbs_pkg::ST_IDLE:
            begin
               if (warm_now || warm_pend && instr_done_in)
                  state <= cbs_pkg::ST_WARM;
               else if (cache_invalidate_instr_in)
                  state <= cbs_pkg::ST_WBACK;
               else if (req_valid_in && straps_taken)
               begin
                  cur           <= req_in;
                  req_ready_out <= 1'b1;
                  second_half   <= 1'b0;
                  beat          <= 2'h0;
                  first_qw      <= req_in.addr[4:3];
                  // fills with no leading single go straight to the burst, so no idle cycle follows ready
                  if (!req_in.line_fill)
                     state <= cbs_pkg::ST_CYCLE;
                  else
                     state <= req_one ? cbs_pkg::ST_SINGLE : cbs_pkg::ST_BURST;
               end
            end
            cbs_pkg::ST_CYCLE:
            begin
               cyc_valid_out     <= 1'b1;
               cyc_out.write     <= cur.write;
               cyc_out.cache_req <= 1'b0;
               cyc_out.burst     <= 1'b0;
               cyc_out.qaddr     <= cur_qw + 29'(second_half);
               cyc_out.byte_en   <= second_half ? hi_mask : lo_mask;
               if (bus_done_in && cyc_valid_out)
               begin
                  cyc_valid_out <= 1'b0;
                  if (splits && !second_half)
                     second_half <= 1'b1;
                  else
                     state <= cbs_pkg::ST_IDLE;
               end
            end
            cbs_pkg::ST_SINGLE:
            begin
               if (!need_one)
                  state <= cbs_pkg::ST_BURST;
               else
               begin
                  cyc_valid_out     <= 1'b1;
                  cyc_out.write     <= 1'b0;
                  cyc_out.cache_req <= 1'b0;
                  cyc_out.burst     <= 1'b0;
                  cyc_out.qaddr     <= cur_qw;
                  cyc_out.byte_en   <= 8'hff;
                  // ack is taken as sampled, never qualified by the request output
                  if (bus_done_in && cyc_valid_out)
                  begin
                     cyc_valid_out <= 1'b0;
                     state <= ack ? cbs_pkg::ST_BURST : cbs_pkg::ST_IDLE;
                  end
               end
            end
            cbs_pkg::ST_BURST:
            begin
               cyc_valid_out     <= 1'b1;
               cyc_out.write     <= 1'b0;
               cyc_out.cache_req <= 1'b1;
               cyc_out.burst     <= 1'b1;
               cyc_out.byte_en   <= 8'hff;
               cyc_out.qaddr     <= {cur_qw[28:2], beat_qw(linear_mode_out, first_qw, 2'h0)};
               beat_qw_out       <= beat_qw(linear_mode_out, first_qw, beat);
               if (bus_done_in && cyc_valid_out)
               begin
                  beat <= beat + 2'h1;
                  if (beat == 2'(cbs_pkg::BURST_BEATS - 3'h1))
                  begin
                     cyc_valid_out    <= 1'b0;
                     line_fill_ok_out <= 1'b1;
                     state            <= cbs_pkg::ST_IDLE;
                  end
               end
            end
            cbs_pkg::ST_WBACK:
            begin
               // dirty lines leave first so nothing modified is dropped
               wb_line_req_out <= line_dirty_in;
               if (!line_dirty_in)
                  state <= cbs_pkg::ST_INVAL;
            end
            cbs_pkg::ST_INVAL:
            begin
               cache_inval_out <= 1'b1;
               state           <= cbs_pkg::ST_IDLE;
            end
            cbs_pkg::ST_WARM:
            begin
               // only the sequencer restarts; cache, buffers and config stay put
               warm_init_out <= 1'b1;
               state         <= cbs_pkg::ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* tb/cbs_sequencer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cbs_monitor
(
   input wire logic                clk_in,
   input wire logic                nrst_in,
   input wire logic                req_ready_out,
   input wire logic                cyc_valid_out,
   input wire cbs_pkg::cbs_cycle_s cyc_out,
   input wire logic                bus_done_in,
   input wire logic                line_dirty_in,
   input wire logic                wb_line_req_out,
   input wire logic                cache_inval_out,
   input wire logic                smm_interrupt_in_n,
   input wire logic                smm_space_access_bit_in,
   input wire logic                smm_entry_instr_in,
   input wire logic                smm_return_instr_in,
   input wire logic                smm_active_out_n,
   input wire logic                smm_space_route_out,
   input wire logic                warm_init_out,
   input wire logic                linear_mode_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////
   chk_ready_then_cycle: assert property (req_ready_out |=> cyc_valid_out && !req_ready_out)
      else $error("bus cycle did not follow acceptance");
   chk_cycle_holds: assert property (cyc_valid_out && !bus_done_in |=> cyc_valid_out && $stable(cyc_out))
      else $error("bus cycle changed before done");
   // a one-cycle gap after done only occurs inside a split or a fill, never between requests
   chk_split_order: assert property (cyc_valid_out && bus_done_in ##1 !cyc_valid_out ##1 cyc_valid_out
      |-> cyc_out.burst || cyc_out.qaddr == $past(cyc_out.qaddr, 2) + 29'h1)
      else $error("upper half of split not at next quadword");
   chk_single_uncached: assert property (cyc_valid_out && !cyc_out.burst |-> !cyc_out.cache_req)
      else $error("cacheable request on single cycle");
   chk_inval_clean: assert property (cache_inval_out |-> !line_dirty_in && !wb_line_req_out ##1 !cache_inval_out)
      else $error("invalidate while modified lines remain");
   // smm active is registered off the service flag, so it follows two edges later
   chk_entry_sets: assert property (smm_entry_instr_in && !smm_return_instr_in |-> ##2 !smm_active_out_n)
      else $error("entry instruction did not raise smm active");
   chk_space_sets: assert property (smm_space_access_bit_in [*3] |-> !smm_active_out_n && smm_space_route_out)
      else $error("space access bit did not route to smm space");
   chk_return_clears: assert property (smm_interrupt_in_n [*6] ##0 (smm_return_instr_in && !smm_entry_instr_in
      && !smm_space_access_bit_in) ##1 !smm_space_access_bit_in |=> smm_active_out_n)
      else $error("return instruction left smm active");
   chk_warm_keeps: assert property (warm_init_out |-> linear_mode_out == $past(linear_mode_out, 2))
      else $error("warm reset changed burst mode");
   cov_split: cover property (cyc_valid_out && bus_done_in ##1 !cyc_valid_out ##1 cyc_valid_out);
   cov_burst: cover property (cyc_valid_out && cyc_out.burst && bus_done_in);
   cov_smm: cover property ($fell(smm_active_out_n));
endmodule
bind cbs_sequencer cbs_monitor mon_u (.clk_in, .nrst_in, .req_ready_out, .cyc_valid_out, .cyc_out, .bus_done_in,
   .line_dirty_in, .wb_line_req_out, .cache_inval_out, .smm_interrupt_in_n, .smm_space_access_bit_in,
   .smm_entry_instr_in, .smm_return_instr_in, .smm_active_out_n, .smm_space_route_out, .warm_init_out,
   .linear_mode_out);
`default_nettype wire

/* tb/cbs_chipset_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbs_chipset
(
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       cyc_valid_out,
   input  wire logic [1:0] wait_cfg_in,
   input  wire logic       ack_n_cfg_in,
   output logic            done_out,
   output logic            cache_ack_n_out
);
   logic [1:0] wait_cnt;
   logic       next_done;
   ////////////////////////////////////////////////////////////
   // each beat of a burst waits its own wait states, so slow fills stretch every transfer
   assign next_done = cyc_valid_out && !done_out && wait_cnt == wait_cfg_in;
   // ack never looks at the cacheable request; off the done cycle it shows the opposite level
   assign cache_ack_n_out = done_out ? ack_n_cfg_in : !ack_n_cfg_in;
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wait_cnt <= 2'h0;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= next_done;
         wait_cnt <= (next_done || done_out || !cyc_valid_out) ? 2'h0 : wait_cnt + 2'h1;
      end
   end
endmodule
`default_nettype wire

/* tb/test_cbs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cbs_sequencer;
   logic clk_in, nrst_in, two_strap_in, ratio_strap_bit0_in, ratio_strap_bit1_in, warm_reset_in, flush_n_in;
   logic sg_enable_strap_n_in, smm_interrupt_in_n, smm_enable_bit_in, smm_space_access_bit_in, smm_entry_instr_in;
   logic smm_return_instr_in, linear_burst_bit_in, linear_burst_we_in, cache_invalidate_instr_in, instr_done_in;
   logic req_valid_in, line_dirty_in, bus_done_in, cacheable_ack_in_n, req_ready_out, cyc_valid_out;
   logic tristate_test_out, self_test_out, sg_enable_out, smm_active_out_n, smm_space_route_out, line_fill_ok_out;
   logic wb_line_req_out, cache_inval_out, warm_init_out, linear_mode_out, ack_n_cfg;
   cbs_pkg::cbs_req_s   req_in;
   cbs_pkg::cbs_cycle_s cyc_out;
   logic [1:0]          beat_qw_out, wait_cfg;
   logic [2:0]          ratio_out;
   logic [41:0]         got_q[$], exp_q[$];
   int                  miscompares = 0, checked = 0;
   int                  fills = 0;
   cbs_sequencer dut_u (.*);
   cbs_chipset chip_u (.clk_in(clk_in), .nrst_in(nrst_in), .cyc_valid_out(cyc_valid_out), .wait_cfg_in(wait_cfg),
      .ack_n_cfg_in(ack_n_cfg), .done_out(bus_done_in), .cache_ack_n_out(cacheable_ack_in_n));
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
      if (cyc_valid_out === 1'b1 && bus_done_in === 1'b1)
         got_q.push_back({cyc_out, cyc_out.burst ? beat_qw_out : 2'h0});
   always @(posedge clk_in)
      if (line_fill_ok_out === 1'b1) fills++;
   task automatic cmp(input string what, input logic [41:0] exp, input logic [41:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge clk_in);
      sig = 1'b0;
      @(negedge clk_in);
   endtask
   // pins: two, bit1, bit0, flush_n, warm, sg_n; exp: ratio, tristate, self test, sg enable
   task automatic reset_with(input logic [5:0] pins, input logic [5:0] exp);
      nrst_in = 1'b0;
      {two_strap_in, ratio_strap_bit1_in, ratio_strap_bit0_in, flush_n_in, warm_reset_in, sg_enable_strap_n_in} = pins;
      repeat (20) @(negedge clk_in);
      nrst_in = 1'b1;
      // straps must outlast the synchroniser and settle count before they move
      repeat (10) @(negedge clk_in);
      cmp("straps", {36'h0, exp}, {36'h0, ratio_out, tristate_test_out, self_test_out, sg_enable_out});
      {flush_n_in, warm_reset_in, sg_enable_strap_n_in} = 3'h5;
      repeat (8) @(negedge clk_in);
   endtask
   // beat[2] marks a burst beat, beat[1:0] its quadword
   task automatic ex(input logic [28:0] qa, input logic [7:0] be, input logic wr, input logic [2:0] beat);
      exp_q.push_back({qa, be, wr, beat[2], beat[2], beat[2] ? beat[1:0] : 2'h0});
   endtask
   task automatic access(input logic [31:0] addr, input logic [3:0] len, input logic wr, input logic fill);
      int i;
      req_in = '{addr, len, wr, fill};
      req_valid_in = 1'b1;
      for (i = 0; i < 20 && req_ready_out !== 1'b1; i++) @(negedge clk_in);
      req_valid_in = 1'b0;
      for (i = 0; i < 80 && got_q.size() < exp_q.size(); i++) @(negedge clk_in);
      repeat (6) @(negedge clk_in);
      cmp("cycle count", 42'(exp_q.size()), 42'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) cmp("bus cycle", exp_q.pop_front(), got_q.pop_front());
      exp_q = {};
      got_q = {};
   endtask
   task automatic test_straps();
      reset_with(6'h25, 6'h28);
      reset_with(6'h29, 6'h34);
      reset_with(6'h3c, 6'h39);
      reset_with(6'h07, 6'h22);
      reset_with(6'h0d, 6'h30);
      reset_with(6'h35, 6'h20);
      cmp("burst mode", 42'h0, {41'h0, linear_mode_out});
   endtask
   task automatic test_split();
      wait_cfg = 2'h2;
      ex(29'h200, 8'h3c, 1'b1, 3'h0);
      access(32'h1002, 4'h4, 1'b1, 1'b0);
      wait_cfg = 2'h0;
      ex(29'h200, 8'hc0, 1'b0, 3'h0);
      ex(29'h201, 8'h03, 1'b0, 3'h0);
      access(32'h1006, 4'h4, 1'b0, 1'b0);
   endtask
   task automatic test_bursts();
      ack_n_cfg = 1'b0;
      ex(29'h201, 8'hff, 1'b0, 3'h0);
      for (int i = 0; i < 4; i++) ex(29'h200, 8'hff, 1'b0, 3'(4 + i));
      access(32'h1008, 4'h8, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++) ex(29'h202, 8'hff, 1'b0, 3'(4 + (i + 2) % 4));
      access(32'h1010, 4'h8, 1'b0, 1'b1);
      ack_n_cfg = 1'b1;
      ex(29'h203, 8'hff, 1'b0, 3'h0);
      access(32'h1018, 4'h8, 1'b0, 1'b1);
      ack_n_cfg = 1'b0;
      linear_burst_bit_in = 1'b1;
      pulse(linear_burst_we_in);
      cmp("burst mode", 42'h1, {41'h0, linear_mode_out});
      for (int i = 0; i < 4; i++) ex(29'h203, 8'hff, 1'b0, 3'(4 + (i + 3) % 4));
      access(32'h1018, 4'h8, 1'b0, 1'b1);
      cmp("line fills", 42'h3, 42'(fills));
   endtask
   task automatic test_invalidate();
      int seen;
      seen = 0;
      line_dirty_in = 1'b1;
      pulse(cache_invalidate_instr_in);
      repeat (3) @(negedge clk_in);
      cmp("write back", 42'h1, {41'h0, wb_line_req_out});
      line_dirty_in = 1'b0;
      repeat (10) @(negedge clk_in) seen += (cache_inval_out === 1'b1);
      cmp("invalidate pulses", 42'h1, 42'(seen));
   endtask
   task automatic test_warm();
      int i;
      warm_reset_in = 1'b1;
      for (i = 0; i < 20 && warm_init_out !== 1'b1; i++) @(negedge clk_in);
      cmp("warm init", 42'h1, {41'h0, warm_init_out});
      cmp("burst mode kept", 42'h1, {41'h0, linear_mode_out});
      warm_reset_in = 1'b0;
      repeat (8) @(negedge clk_in);
   endtask
   task automatic test_smm();
      smm_enable_bit_in = 1'b1;
      smm_interrupt_in_n = 1'b0;
      repeat (8) @(negedge clk_in);
      cmp("smm active", 42'h0, {41'h0, smm_active_out_n});
      smm_interrupt_in_n = 1'b1;
      repeat (8) @(negedge clk_in);
      pulse(smm_return_instr_in);
      cmp("smm active", 42'h1, {41'h0, smm_active_out_n});
      pulse(smm_entry_instr_in);
      cmp("smm active", 42'h0, {41'h0, smm_active_out_n});
      pulse(smm_return_instr_in);
      smm_space_access_bit_in = 1'b1;
      repeat (4) @(negedge clk_in);
      cmp("smm route", 42'h2, {40'h0, smm_space_route_out, smm_active_out_n});
      smm_space_access_bit_in = 1'b0;
   endtask
   initial
   begin
      {two_strap_in, ratio_strap_bit0_in, ratio_strap_bit1_in, warm_reset_in, smm_enable_bit_in, nrst_in} = '0;
      {smm_space_access_bit_in, smm_entry_instr_in, smm_return_instr_in, linear_burst_bit_in} = '0;
      {linear_burst_we_in, cache_invalidate_instr_in, req_valid_in, line_dirty_in} = '0;
      {flush_n_in, sg_enable_strap_n_in, smm_interrupt_in_n, instr_done_in, ack_n_cfg} = '1;
      req_in = '0;
      wait_cfg = 2'h1;
      @(negedge clk_in);
      test_straps();
      test_split();
      test_bursts();
      test_invalidate();
      test_warm();
      test_smm();
      results();
   end
   initial
   begin
      #(40 * 4000);
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
